/* File: sfod_core.sv */
// sfod core: serial flash opcode decoder with write-data fifo
//
// Behaviour
// - 03h/0Bh: three address, zero/one dummy, stream
// - 3Bh: single-line address, dummy, dual output
// - BBh: two-line address, 1(2) dummy bytes
// - 6Bh: address, one dummy, quad output
// - EBh: four-line address, 3(5) dummy bytes
// - E7h: four-line address, one dummy, words
// - 81h/20h: three address bytes, nothing more
// - 52h/D8h addressed, 60h/C7h whole array
// - 02h/32h: address then data, 32h quad
// - 06h sets, 04h clears write latch
// - 50h arms volatile status write
// - 36h/39h/3Dh single block lock commands
// - 7Eh/98h lock or unlock all blocks
// - 44h/42h/48h security area commands
// - 05h/35h/15h return one register byte
// - 01h/31h/11h write one register byte
// - 9Eh clears buffer, 9Ah loads it
// - 9Bh reads buffer, 9Ch writes buffer
// - 9Dh commits buffer to array page
// - 9Fh returns maker then two part bytes
// - 90h/92h/94h id on one/two/four lines
// - FFh leaves enhanced read state
// - 66h then 99h resets, busy 30us
// - write-type commands need byte-aligned chip-select rise
// - unknown opcode: outputs off until next frame
// - four-line commands need quad enable bit
`timescale 1ns/10ps

// ****************************************
// write-data fifo
// ****************************************
module sfod_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic push;
  logic pop;
  assign in_ready_out = cnt != (AW+1)'(DEPTH);
  assign out_valid_out = cnt != '0;
  assign out_data_out = mem[rp];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem[wp] <= in_data_in;
  end
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end
    else
    begin
      if (push)
        wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
      if (pop)
        rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sfod_fifo

// ****************************************
// opcode decoder
// ****************************************
module sfod_core #(
  parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary
  parameter logic [15:0] PART_ID = 16'h1234 // arbitrary
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // serial pins
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_out,
  // configuration
  input wire logic dummy_alt_in,
  input wire logic busy_in,
  // read data
  input wire logic [7:0] rd_data_in,
  output logic rd_next_out,
  // write data
  output logic [7:0] wr_data_out,
  output logic wr_valid_out,
  input wire logic wr_ready_in,
  output logic wr_overflow_out,
  // commands and state
  output logic cmd_valid_out,
  output sfod_pkg::sfod_cmd_t cmd_out,
  output logic wel_out,
  output logic quad_io_allow_out,
  output logic enhanced_out,
  output logic resetting_out,
  output logic [7:0] status0_out,
  output logic [7:0] status1_out,
  output logic [7:0] config_out
);
  import sfod_pkg::*;

  function automatic sfod_desc_t mk(int ab, int db,
    int da, sfod_width_t aw, sfod_width_t dw, sfod_dir_t dir,
    sfod_src_t src);
    mk = '{1'b1, dw == SFOD_W4 || aw == SFOD_W4, 2'(ab), 3'(db), 3'(da),
      aw, dw, dir, src};
  endfunction : mk

  function automatic sfod_desc_t dec(logic [7:0] op);
    dec = '0;
    unique case (op)
      OP_RDSLOW: dec = mk(3, 0, 0, SFOD_W1, SFOD_W1, SFOD_OUT, SRC_USER);
      OP_RDFAST, OP_SARD, OP_BUFRD:
        dec = mk(3, 1, 1, SFOD_W1, SFOD_W1, SFOD_OUT, SRC_USER);
      OP_RD2OUT: dec = mk(3, 1, 1, SFOD_W1, SFOD_W2, SFOD_OUT, SRC_USER);
      OP_RD2IO: dec = mk(3, 1, 2, SFOD_W2, SFOD_W2, SFOD_OUT, SRC_USER);
      OP_RD4OUT: dec = mk(3, 1, 1, SFOD_W1, SFOD_W4, SFOD_OUT, SRC_USER);
      OP_RD4IO: dec = mk(3, 3, 5, SFOD_W4, SFOD_W4, SFOD_OUT, SRC_USER);
      OP_RD4WD: dec = mk(3, 1, 1, SFOD_W4, SFOD_W4, SFOD_OUT, SRC_USER);
      OP_PGWIPE, OP_SECWIPE, OP_B32WIPE, OP_B64WIPE, OP_LOCK, OP_UNLOCK,
      OP_SAWIPE, OP_BUFLD, OP_BUFPG:
        dec = mk(3, 0, 0, SFOD_W1, SFOD_W1, SFOD_NONE, SRC_USER);
      OP_LOCKQ: dec = mk(3, 0, 0, SFOD_W1, SFOD_W1, SFOD_OUT, SRC_USER);
      OP_CHIP0, OP_CHIP1, OP_WLSET, OP_WLCLR, OP_VOLUNL, OP_ALLLOCK,
      OP_ALLUNL, OP_BUFCLR, OP_RSTARM, OP_RSTGO, OP_RELEASE:
        dec = mk(0, 0, 0, SFOD_W1, SFOD_W1, SFOD_NONE, SRC_USER);
      OP_PGWR, OP_SAWR, OP_BUFWR:
        dec = mk(3, 0, 0, SFOD_W1, SFOD_W1, SFOD_IN, SRC_USER);
      OP_PGWR4: dec = mk(3, 0, 0, SFOD_W1, SFOD_W4, SFOD_IN, SRC_USER);
      OP_ST0RD, OP_ST1RD, OP_CFGRD:
        dec = mk(0, 0, 0, SFOD_W1, SFOD_W1, SFOD_OUT, SRC_REG);
      OP_ST0WR, OP_ST1WR, OP_CFGWR:
        dec = mk(0, 0, 0, SFOD_W1, SFOD_W1, SFOD_IN, SRC_USER);
      OP_ID3: dec = mk(0, 0, 0, SFOD_W1, SFOD_W1, SFOD_OUT, SRC_ID3);
      OP_ID1: dec = mk(3, 0, 0, SFOD_W1, SFOD_W1, SFOD_OUT, SRC_ID2);
      OP_ID2L: dec = mk(3, 1, 1, SFOD_W2, SFOD_W2, SFOD_OUT, SRC_ID2);
      OP_ID4L: dec = mk(3, 1, 1, SFOD_W4, SFOD_W4, SFOD_OUT, SRC_ID2);
      default: dec = '0;
    endcase
  endfunction : dec

  function automatic logic [5:0] dcyc(logic [2:0] n, sfod_width_t w);
    unique case (w)
      SFOD_W2: dcyc = {1'b0, n, 2'b00};
      SFOD_W4: dcyc = {2'b00, n, 1'b0};
      default: dcyc = {n, 3'b000};
    endcase
  endfunction : dcyc

  function automatic sfod_phase_t after_dummy(sfod_desc_t x);
    if (x.dir == SFOD_OUT)
      after_dummy = PH_DOUT;
    else if (x.dir == SFOD_IN)
      after_dummy = PH_DIN;
    else
      after_dummy = PH_DONE;
  endfunction : after_dummy

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] cs_sy;
  logic [2:0] ck_sy;
  logic [3:0] io_s1;
  logic [3:0] io_s2;
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      cs_sy <= 3'h7;
      ck_sy <= 3'h0;
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
    end
    else
    begin
      cs_sy <= {cs_sy[1:0], cs_n_in};
      ck_sy <= {ck_sy[1:0], sclk_in};
      io_s1 <= io_in;
      io_s2 <= io_s1;
    end
  end
  logic cs_fall;
  logic cs_rise;
  logic rise;
  logic fall;
  assign cs_fall = cs_sy[2] && !cs_sy[1];
  assign cs_rise = !cs_sy[2] && cs_sy[1];
  assign rise = ck_sy[1] && !ck_sy[2] && !cs_sy[1];
  assign fall = !ck_sy[1] && ck_sy[2] && !cs_sy[1];

  // ****************************************
  // input shifting
  // ****************************************
  sfod_phase_t ph;
  sfod_desc_t d;
  logic [7:0] op;
  logic [7:0] sr;
  logic [7:0] next_sr;
  logic [2:0] bc;
  logic [2:0] next_bc;
  logic [1:0] byc;
  logic [23:0] addr;
  logic [5:0] dcnt;
  logic [5:0] dtarget;
  logic enhanced;
  logic enh_pend;
  logic qio;
  logic resetting;
  sfod_width_t w;
  sfod_desc_t nd;
  logic byte_done;
  always_comb
  begin
    w = SFOD_W1;
    if (ph == PH_ADDR || ph == PH_DUMMY)
      w = d.aw;
    else if (ph == PH_DIN)
      w = d.dw;
  end
  always_comb
  begin
    unique case (w)
      SFOD_W2: next_sr = {sr[5:0], io_s2[1:0]};
      SFOD_W4: next_sr = {sr[3:0], io_s2};
      default: next_sr = {sr[6:0], io_s2[0]};
    endcase
  end
  assign next_bc = bc + (3'b001 << w);
  assign byte_done = rise && next_bc == 3'h0;
  assign nd = dec(next_sr);
  assign dtarget = dcyc(dummy_alt_in ? d.dalt : d.dbytes, d.aw);
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || cs_fall)
    begin
      sr <= 8'h00;
      bc <= 3'h0;
    end
    else if (rise)
    begin
      sr <= next_sr;
      bc <= next_bc;
    end
  end

  // ****************************************
  // phase sequencing
  // ****************************************
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || cs_rise)
      ph <= PH_IDLE;
    else if (cs_fall)
      ph <= resetting ? PH_SKIP : enhanced ? PH_ADDR : PH_OPC;
    else if (ph == PH_OPC && byte_done)
    begin
      if (!nd.known || (nd.quad && !qio))
        ph <= PH_SKIP;
      else if (nd.abytes != 2'd0)
        ph <= PH_ADDR;
      else
        ph <= after_dummy(nd);
    end
    else if (ph == PH_ADDR && byte_done)
    begin
      if (enhanced && byc == 2'd0 && next_sr == OP_RELEASE)
        ph <= PH_SKIP;
      else if (byc == d.abytes - 2'd1)
        ph <= dtarget != 6'd0 ? PH_DUMMY : after_dummy(d);
    end
    else if (ph == PH_DUMMY && rise && dcnt + 6'd1 == dtarget)
      ph <= after_dummy(d);
  end
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      d <= '0;
      op <= 8'h00;
    end
    else if (cs_fall && enhanced)
    begin
      d <= dec(OP_RD4IO);
      op <= OP_RD4IO;
    end
    else if (ph == PH_OPC && byte_done)
    begin
      d <= nd;
      op <= next_sr;
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || cs_fall)
    begin
      byc <= 2'd0;
      addr <= 24'h0;
      dcnt <= 6'd0;
    end
    else if (ph == PH_ADDR && byte_done)
    begin
      byc <= byc + 2'd1;
      addr <= {addr[15:0], next_sr};
    end
    else if (ph == PH_DUMMY && rise)
      dcnt <= dcnt + 6'd1;
  end

  // ****************************************
  // output shifting
  // ****************************************
  logic [7:0] obuf;
  logic [2:0] ocnt;
  logic [1:0] idx;
  logic [7:0] src;
  logic [7:0] st0_view;
  logic ofetch;
  assign st0_view = {status0_out[7:2], wel_out, busy_in};
  assign ofetch = fall && ph == PH_DOUT && ocnt == 3'h0;
  assign rd_next_out = ofetch && d.src == SRC_USER;
  always_comb
  begin
    src = obuf;
    if (ocnt == 3'h0)
    begin
      unique case (d.src)
        SRC_ID3: src = idx == 2'd0 ? MAKER_ID :
          idx == 2'd1 ? PART_ID[15:8] : PART_ID[7:0];
        SRC_ID2: src = idx[0] ? PART_ID[7:0] : MAKER_ID;
        SRC_REG: src = op == OP_ST0RD ? st0_view :
          op == OP_ST1RD ? status1_out : config_out;
        default: src = rd_data_in;
      endcase
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || cs_fall)
    begin
      obuf <= 8'h00;
      ocnt <= 3'h0;
      idx <= 2'd0;
    end
    else if (fall && ph == PH_DOUT)
    begin
      obuf <= src << (3'b001 << d.dw);
      ocnt <= ocnt + (3'b001 << d.dw);
      if (ofetch)
        idx <= (idx == 2'd2) ? 2'd0 : idx + 2'd1;
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || ph != PH_DOUT)
    begin
      io_out <= 4'h0;
      io_oe_out <= 4'h0;
    end
    else if (fall)
    begin
      unique case (d.dw)
        SFOD_W2:
        begin
          io_out <= {2'b00, src[7:6]};
          io_oe_out <= 4'h3;
        end
        SFOD_W4:
        begin
          io_out <= src[7:4];
          io_oe_out <= 4'hf;
        end
        default:
        begin
          io_out <= {2'b00, src[7], 1'b0};
          io_oe_out <= 4'h2;
        end
      endcase
    end
  end

  // ****************************************
  // write data path
  // ****************************************
  logic is_regwr;
  logic din_byte;
  logic [7:0] wbyte;
  logic got;
  logic push_ready;
  assign is_regwr = op == OP_ST0WR || op == OP_ST1WR || op == OP_CFGWR;
  assign din_byte = ph == PH_DIN && byte_done;
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || cs_fall)
    begin
      wbyte <= 8'h00;
      got <= 1'b0;
    end
    else if (din_byte && !got)
    begin
      wbyte <= next_sr;
      got <= 1'b1;
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || cs_fall)
      wr_overflow_out <= 1'b0;
    else if (din_byte && !is_regwr && !push_ready)
      wr_overflow_out <= 1'b1;
  end
  sfod_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(din_byte && !is_regwr),
    .in_ready_out(push_ready),
    .in_data_in(next_sr),
    .out_valid_out(wr_valid_out),
    .out_ready_in(wr_ready_in),
    .out_data_out(wr_data_out)
  );

  // ****************************************
  // commit, latches and soft reset
  // ****************************************
  logic aligned;
  logic commit;
  logic rd_open;
  logic vol;
  logic arm;
  logic [9:0] rcnt;
  assign aligned = bc == 3'h0 && (ph == PH_DONE || (ph == PH_DIN && got));
  assign commit = cs_rise && aligned;
  assign rd_open = ph == PH_ADDR && byte_done && d.dir == SFOD_OUT &&
    byc == d.abytes - 2'd1;
  assign qio = status1_out[QIO_BIT];
  assign quad_io_allow_out = qio;
  assign enhanced_out = enhanced;
  assign resetting = rcnt != 10'd0;
  assign resetting_out = resetting;
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      cmd_valid_out <= 1'b0;
      cmd_out <= '0;
    end
    else
    begin
      cmd_valid_out <= commit || rd_open;
      if (commit || rd_open)
        cmd_out <= '{op, rd_open ? {addr[15:0], next_sr} : addr, vol};
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      wel_out <= 1'b0;
    else if (commit && op == OP_WLSET)
      wel_out <= 1'b1;
    else if (commit || (cs_rise && resetting))
      wel_out <= 1'b0;
  end
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      vol <= 1'b0;
    else if (commit)
      vol <= op == OP_VOLUNL;
    else if (resetting)
      vol <= 1'b0;
  end
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      status0_out <= REG_INIT;
      status1_out <= REG_INIT;
      config_out <= REG_INIT;
    end
    else if (commit && is_regwr && (wel_out || vol))
    begin
      if (op == OP_ST0WR)
        status0_out <= wbyte;
      else if (op == OP_ST1WR)
        status1_out <= wbyte;
      else
        config_out <= wbyte;
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      arm <= 1'b0;
      rcnt <= 10'd0;
    end
    else
    begin
      if (commit)
        arm <= op == OP_RSTARM;
      if (commit && op == OP_RSTGO && arm)
        rcnt <= RST_CNT;
      else if (resetting)
        rcnt <= rcnt - 10'd1;
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || cs_fall)
      enh_pend <= 1'b0;
    else if (op == OP_RD4IO && ph == PH_DUMMY && rise && dcnt == 6'd1)
      enh_pend <= next_sr == ENH_MODE;
  end
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || resetting)
      enhanced <= 1'b0;
    else if (ph == PH_OPC && byte_done && next_sr == OP_RELEASE)
      enhanced <= 1'b0;
    else if (ph == PH_ADDR && enhanced && byc == 2'd0 && byte_done &&
      next_sr == OP_RELEASE)
      enhanced <= 1'b0;
    else if (cs_rise)
      enhanced <= enh_pend && ph == PH_DOUT;
  end

  // ****************************************
  // assertions
  // ****************************************
  wel_set_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    commit && op == OP_WLSET |=> wel_out)
    else $error("write latch not set");
  wel_clr_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    commit && op == OP_WLCLR |=> !wel_out)
    else $error("write latch not cleared");
  skip_quiet_a: assert property (@(posedge clk_in)
    disable iff (!resetn_in) ph == PH_SKIP |=> io_oe_out == 4'h0)
    else $error("output driven while ignoring");
  rise_abort_a: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    cs_rise |=> ph == PH_IDLE && cmd_valid_out == $past(aligned))
    else $error("frame not aborted");
  quad_gate_a: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    ph == PH_OPC && byte_done && nd.quad && !qio |=> ph == PH_SKIP)
    else $error("quad command accepted without enable");
  reset_hold_a: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    $rose(resetting) |-> resetting [*8] ##0 rcnt == RST_CNT - 10'd7)
    else $error("reset period wrong");
  aligned_only_a: assert property (@(posedge clk_in)
    disable iff (!resetn_in) cs_rise && bc != 3'h0 |=> !cmd_valid_out)
    else $error("unaligned command committed");
  dummy_len_a: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    $rose(ph == PH_DOUT) && $past(ph) == PH_DUMMY |-> dcnt == dtarget)
    else $error("dummy length wrong");
endmodule : sfod_core

/* File: sfod_pkg.sv */
// sfod package: opcodes, widths, phases and command records
package sfod_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned RST_US = 30;
  localparam int unsigned RST_CYC = (RST_US * CLK_HZ + 999_999) / 1_000_000;
  localparam logic [9:0] RST_CNT = 10'(RST_CYC);
  localparam int WEL_BIT = 1;
  localparam int QIO_BIT = 1;
  localparam logic [7:0] REG_INIT = 8'h00;
  localparam logic [7:0] ENH_MODE = 8'h20;
  localparam logic [7:0] OP_RDSLOW = 8'h03;
  localparam logic [7:0] OP_RDFAST = 8'h0b;
  localparam logic [7:0] OP_RD2OUT = 8'h3b;
  localparam logic [7:0] OP_RD2IO = 8'hbb;
  localparam logic [7:0] OP_RD4OUT = 8'h6b;
  localparam logic [7:0] OP_RD4IO = 8'heb;
  localparam logic [7:0] OP_RD4WD = 8'he7;
  localparam logic [7:0] OP_PGWIPE = 8'h81;
  localparam logic [7:0] OP_SECWIPE = 8'h20;
  localparam logic [7:0] OP_B32WIPE = 8'h52;
  localparam logic [7:0] OP_B64WIPE = 8'hd8;
  localparam logic [7:0] OP_CHIP0 = 8'h60;
  localparam logic [7:0] OP_CHIP1 = 8'hc7;
  localparam logic [7:0] OP_PGWR = 8'h02;
  localparam logic [7:0] OP_PGWR4 = 8'h32;
  localparam logic [7:0] OP_WLSET = 8'h06;
  localparam logic [7:0] OP_WLCLR = 8'h04;
  localparam logic [7:0] OP_VOLUNL = 8'h50;
  localparam logic [7:0] OP_LOCK = 8'h36;
  localparam logic [7:0] OP_UNLOCK = 8'h39;
  localparam logic [7:0] OP_LOCKQ = 8'h3d;
  localparam logic [7:0] OP_ALLLOCK = 8'h7e;
  localparam logic [7:0] OP_ALLUNL = 8'h98;
  localparam logic [7:0] OP_SAWIPE = 8'h44;
  localparam logic [7:0] OP_SAWR = 8'h42;
  localparam logic [7:0] OP_SARD = 8'h48;
  localparam logic [7:0] OP_ST0RD = 8'h05;
  localparam logic [7:0] OP_ST1RD = 8'h35;
  localparam logic [7:0] OP_CFGRD = 8'h15;
  localparam logic [7:0] OP_ST0WR = 8'h01;
  localparam logic [7:0] OP_ST1WR = 8'h31;
  localparam logic [7:0] OP_CFGWR = 8'h11;
  localparam logic [7:0] OP_BUFCLR = 8'h9e;
  localparam logic [7:0] OP_BUFLD = 8'h9a;
  localparam logic [7:0] OP_BUFRD = 8'h9b;
  localparam logic [7:0] OP_BUFWR = 8'h9c;
  localparam logic [7:0] OP_BUFPG = 8'h9d;
  localparam logic [7:0] OP_RSTARM = 8'h66;
  localparam logic [7:0] OP_RSTGO = 8'h99;
  localparam logic [7:0] OP_ID3 = 8'h9f;
  localparam logic [7:0] OP_ID1 = 8'h90;
  localparam logic [7:0] OP_ID2L = 8'h92;
  localparam logic [7:0] OP_ID4L = 8'h94;
  localparam logic [7:0] OP_RELEASE = 8'hff;
  typedef enum logic [1:0] {SFOD_W1 = 2'b00, SFOD_W2 = 2'b01,
    SFOD_W4 = 2'b10} sfod_width_t;
  typedef enum logic [1:0] {SFOD_NONE = 2'b00, SFOD_IN = 2'b01,
    SFOD_OUT = 2'b10} sfod_dir_t;
  typedef enum logic [1:0] {SRC_USER = 2'b00, SRC_ID3 = 2'b01,
    SRC_ID2 = 2'b10, SRC_REG = 2'b11} sfod_src_t;
  typedef enum logic [2:0] {PH_IDLE = 3'b000, PH_OPC = 3'b001,
    PH_ADDR = 3'b010, PH_DUMMY = 3'b011, PH_DIN = 3'b100,
    PH_DOUT = 3'b101, PH_DONE = 3'b110, PH_SKIP = 3'b111} sfod_phase_t;
  typedef struct packed {
    logic known;
    logic quad;
    logic [1:0] abytes;
    logic [2:0] dbytes;
    logic [2:0] dalt;
    sfod_width_t aw;
    sfod_width_t dw;
    sfod_dir_t dir;
    sfod_src_t src;
  } sfod_desc_t;
  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
    logic vol;
  } sfod_cmd_t;
endpackage : sfod_pkg

/* File: sfod_host.sv */
// serial host model for the opcode decoder
`timescale 1ns/10ps
module sfod_host #(
  parameter int HALF = 6
) (
  // clock
  input wire logic clk_in,
  // pins
  output logic cs_n_out,
  output logic sclk_out,
  output logic [3:0] io_out,
  output logic io_oe_out,
  input wire logic [3:0] io_in
);
  initial
  begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    io_out = 4'h0;
    io_oe_out = 1'b0;
  end
  // ****************************************
  // frame tasks
  // ****************************************
  task automatic start();
    repeat (8) @(posedge clk_in);
    cs_n_out <= 1'b0;
  endtask : start
  // w bits per serial clock
  task automatic xfer(input int w, input logic drv,
    input logic [7:0] tx, output logic [7:0] rx);
    int i;
    logic [3:0] m;
    m = 4'((1 << w) - 1);
    rx = 8'h00;
    for (i = 8 - w; i >= 0; i -= w)
    begin
      sclk_out <= 1'b0;
      io_out <= 4'(tx >> i) & m;
      io_oe_out <= drv;
      repeat (HALF) @(posedge clk_in);
      sclk_out <= 1'b1;
      // single-line reads come back on io1
      rx = (rx << w) | 8'((w == 1 ? io_in >> 1 : io_in) & m);
      repeat (HALF) @(posedge clk_in);
    end
  endtask : xfer
  task automatic stop();
    sclk_out <= 1'b0;
    io_oe_out <= 1'b0;
    repeat (HALF) @(posedge clk_in);
    cs_n_out <= 1'b1;
  endtask : stop
endmodule : sfod_host

/* File: serial_flash_opcode_decoder_tb_top.sv */
// self-checking bench for the opcode decoder
`timescale 1ns/10ps
module serial_flash_opcode_decoder_tb_top;
  import sfod_pkg::*;
  localparam logic [7:0] MAKER = 8'h3c; // arbitrary
  localparam logic [15:0] PART = 16'hc0de; // arbitrary
  localparam logic [7:0] ROP [4] = '{OP_RDSLOW, OP_RDFAST, OP_RD2OUT,
    OP_RD4OUT};
  localparam int RW [4] = '{1, 1, 2, 4};
  logic clk_in, resetn_in, busy, wr_ready, cs_n, sclk, h_oe;
  logic wr_valid, wr_ovf, wel, qio, rst_busy, alt, rd_nx, cmd_v, enh;
  logic [3:0] h_io, d_io, d_oe;
  wire logic [3:0] io_w;
  logic [7:0] wr_data, st0, st1, cfg;
  sfod_cmd_t cmd;
  int errors = 0;
  int checks_done = 0;
  int n_cmd = 0;
  int n_rd = 0;
  // released lines show the inverse of the last value
  assign io_w = (d_oe & d_io) | (~d_oe & (h_oe ? h_io : ~h_io));
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  sfod_host u_host (.clk_in(clk_in), .cs_n_out(cs_n), .sclk_out(sclk),
    .io_out(h_io), .io_oe_out(h_oe), .io_in(io_w));
  sfod_core #(.MAKER_ID(MAKER), .PART_ID(PART)) u_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .cs_n_in(cs_n),
    .sclk_in(sclk), .io_in(io_w), .io_out(d_io), .io_oe_out(d_oe),
    .dummy_alt_in(alt), .busy_in(busy), .rd_data_in(8'ha5),
    .rd_next_out(rd_nx), .wr_data_out(wr_data), .wr_valid_out(wr_valid),
    .wr_ready_in(wr_ready), .wr_overflow_out(wr_ovf),
    .cmd_valid_out(cmd_v), .cmd_out(cmd), .wel_out(wel),
    .quad_io_allow_out(qio), .enhanced_out(enh), .resetting_out(rst_busy),
    .status0_out(st0), .status1_out(st1), .config_out(cfg));
  // one-cycle strobe counters
  always @(posedge clk_in)
  begin
    if (cmd_v === 1'b1)
      n_cmd <= n_cmd + 1;
    if (rd_nx === 1'b1)
      n_rd <= n_rd + 1;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    checks_done++;
    if (seen !== want)
    begin
      errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic go(input logic [7:0] op, input int na,
    input logic [23:0] a);
    logic [7:0] r;
    int k;
    u_host.start();
    u_host.xfer(1, 1'b1, op, r);
    for (k = na - 1; k >= 0; k--)
      u_host.xfer(1, 1'b1, a[8*k +: 8], r);
  endtask : go
  task automatic fin();
    u_host.stop();
    repeat (8) @(posedge clk_in);
  endtask : fin
  task automatic op0(input logic [7:0] op);
    go(op, 0, 24'h0);
    fin();
  endtask : op0
  task automatic wr1(input logic [7:0] op, input logic [7:0] d);
    logic [7:0] r;
    op0(OP_WLSET);
    go(op, 0, 24'h0);
    u_host.xfer(1, 1'b1, d, r);
    fin();
  endtask : wr1
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  // ****************************************
  // tests
  // ****************************************
  initial
  begin : main
    logic [7:0] q, q2, q3;
    int k, n, nr;
    resetn_in = 1'b0;
    busy = 1'b0;
    wr_ready = 1'b0;
    alt = 1'b0;
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    op0(OP_WLSET);
    check(wel, 1);
    op0(OP_WLCLR);
    check({cmd.opcode, wel}, {OP_WLCLR, 1'b0});
    go(OP_WLSET, 0, 24'h0);
    u_host.xfer(4, 1'b1, 8'h00, q);
    fin();
    check(wel, 0);
    op0(OP_WLSET);
    busy <= 1'b1;
    go(OP_ST0RD, 0, 24'h0);
    u_host.xfer(1, 1'b0, 8'h00, q);
    fin();
    busy <= 1'b0;
    check(q, 8'h03);
    wr1(OP_ST0WR, 8'h3c);
    check({st0, wel}, {8'h3c, 1'b0});
    wr1(OP_CFGWR, 8'h96);
    check(cfg, 8'h96);
    go(OP_RD4OUT, 3, 24'h0);
    u_host.xfer(1, 1'b1, 8'h00, q);
    u_host.xfer(4, 1'b0, 8'h00, q);
    check(d_oe, 4'h0);
    fin();
    wr1(OP_ST1WR, 8'h02);
    check({qio, st1}, {1'b1, 8'h02});
    n = n_cmd;
    nr = n_rd;
    for (k = 0; k < 4; k++)
    begin
      go(ROP[k], 3, 24'h123450 + 24'(k));
      if (k > 0)
        u_host.xfer(1, 1'b1, 8'h00, q);
      u_host.xfer(RW[k], 1'b0, 8'h00, q);
      u_host.xfer(RW[k], 1'b0, 8'h00, q2);
      fin();
      check({q, q2}, 16'ha5a5);
      check({cmd.opcode, cmd.addr}, {ROP[k], 24'h123450 + 24'(k)});
    end
    check(n_cmd - n, 4);
    check(n_rd - nr, 12);
    alt <= 1'b1;
    u_host.start();
    u_host.xfer(1, 1'b1, OP_RD4IO, q);
    for (k = 0; k < 8; k++)
      u_host.xfer(4, 1'b1, (k == 3) ? ENH_MODE : 8'h00, q);
    u_host.xfer(4, 1'b0, 8'h00, q);
    fin();
    check({q, enh, cmd.opcode}, {8'ha5, 1'b1, OP_RD4IO});
    u_host.start();
    u_host.xfer(4, 1'b1, OP_RELEASE, q);
    fin();
    check(enh, 0);
    go(OP_ID3, 0, 24'h0);
    u_host.xfer(1, 1'b0, 8'h00, q);
    u_host.xfer(1, 1'b0, 8'h00, q2);
    u_host.xfer(1, 1'b0, 8'h00, q3);
    fin();
    check({q, q2, q3}, {MAKER, PART});
    go(8'h00, 0, 24'h0);
    u_host.xfer(1, 1'b0, 8'h00, q);
    check(d_oe, 4'h0);
    fin();
    op0(OP_WLSET);
    go(OP_PGWR, 3, 24'h000100);
    for (k = 0; k < 5; k++)
      u_host.xfer(1, 1'b1, 8'h11 + 8'(k), q);
    fin();
    check({cmd.opcode, wr_ovf}, {OP_PGWR, 1'b1});
    for (k = 0; k < 4; k++)
    begin
      n = 0;
      while (wr_valid !== 1'b1 && n < 50)
      begin
        @(posedge clk_in);
        n++;
      end
      check(wr_data, 8'h11 + 8'(k));
      wr_ready <= 1'b1;
      @(posedge clk_in);
      wr_ready <= 1'b0;
      @(posedge clk_in);
    end
    check(wr_valid, 0);
    op0(OP_WLSET);
    op0(OP_RSTARM);
    op0(OP_RSTGO);
    check({rst_busy, wel}, 2'b10);
    op0(OP_WLSET);
    check(wel, 0);
    repeat (700) @(posedge clk_in);
    check(rst_busy, 0);
    print_verdict();
  end
  // watchdog
  initial
  begin
    repeat (40000) @(posedge clk_in);
    errors++;
    print_verdict();
  end
endmodule : serial_flash_opcode_decoder_tb_top
